// ===== common/tbe_pkg.sv
// Shared constants and types for the bit-level two-wire engine
package tbe_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] TBE_IDX_CONFIG  = 8'hC8;
    localparam logic [7:0] TBE_IDX_CONTROL = 8'hD8;
    localparam logic [7:0] TBE_IDX_DATA    = 8'hD9;
    localparam int         TBE_ADDR_W      = 10;

    // Data register field position
    localparam int TBE_DATA_BIT = 7;

    // Reset and answer values
    localparam logic [31:0] TBE_READ_NONE = 32'h0000_0000;

    // Minimum bus phase time: one timing step in clk_i cycles
    localparam int TBE_MIN_STEP_CYCLES = 8;
    localparam int TBE_CNT_W           = 8;

    // Control register, write view
    typedef struct packed {
        logic clr_xact;
        logic ignore_bus;
        logic clr_ready;
        logic clr_lost;
        logic clr_start;
        logic clr_stop;
        logic rstart_req;
        logic stop_req;
    } tbe_ctl_wr_type;

    // Control register, read view
    typedef struct packed {
        logic rx_bit;
        logic attention;
        logic ready;
        logic lost;
        logic start_seen;
        logic stop_seen;
        logic owner;
        logic rsvd;
    } tbe_ctl_rd_type;

    // Configuration register
    typedef struct packed {
        logic       slave_en;
        logic       own_req;
        logic [3:0] rsvd;
        logic [1:0] timing;
    } tbe_cfg_type;

    localparam tbe_cfg_type TBE_CFG_RESET = '0;

    typedef enum {
        TBE_M_IDLE,
        TBE_M_START,
        TBE_M_LOW,
        TBE_M_RISE,
        TBE_M_HIGH,
        TBE_M_RSTART,
        TBE_M_STOP
    } tbe_mst_state_type;

endpackage : tbe_pkg

// ===== hw/tbe_engine.sv
// Bit-level two-wire serial engine with Avalon-MM register access
`timescale 1ns/1ps

module tbe_engine
    import tbe_pkg::*;
#(
    parameter int MIN_STEP = TBE_MIN_STEP_CYCLES
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic [TBE_ADDR_W-1:0] avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [31:0]           avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire logic                  scl_i,
    output logic                       scl_o,
    output logic                       scl_oe_n_o,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe_n_o
);

    logic                  scl_m, scl_s, scl_d;
    logic                  sda_m, sda_s, sda_d;
    logic                  scl_rise, start_det, stop_det;
    logic                  take, wr_ctl, wr_cfg, wr_data, rd_data;
    logic [7:0]            widx;
    tbe_ctl_wr_type        ctl_w;
    tbe_ctl_rd_type        ctl_r;
    tbe_cfg_type           cfg;
    logic                  ready_flag, lost_flag, start_flag, stop_flag;
    logic                  owner, busy, ignore;
    logic                  xact, xbit, rx_sample, rs_pend, sp_pend, rel_pend;
    logic                  attention, active, lost_set;
    tbe_mst_state_type     st, next_st;
    logic [TBE_CNT_W-1:0]  cnt, next_cnt, min_cnt;
    logic                  next_scl_drive, next_sda_drive;

    // Pins come from another clock domain: two stages before any use
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce_i) begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // Bus slave: one wait cycle, then the access takes effect
    assign take    = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign widx    = avs_address_i[TBE_ADDR_W-1:2];
    assign ctl_w   = tbe_ctl_wr_type'(avs_writedata_i[7:0]);
    assign wr_ctl  = take & avs_write_i & avs_byteenable_i[0]
                     & (widx == TBE_IDX_CONTROL);
    assign wr_cfg  = take & avs_write_i & avs_byteenable_i[0]
                     & (widx == TBE_IDX_CONFIG);
    assign wr_data = take & avs_write_i & avs_byteenable_i[0]
                     & (widx == TBE_IDX_DATA);
    assign rd_data = take & avs_read_i & (widx == TBE_IDX_DATA);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (ce_i) begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i)
                                   & avs_waitrequest_o);
        end
    end

    assign attention = ready_flag | lost_flag
                       | start_flag | stop_flag;
    assign active    = owner | (cfg.slave_en & ~ignore);
    assign ctl_r     = '{rx_bit: rx_sample, attention: attention,
                         ready: ready_flag, lost: lost_flag,
                         start_seen: start_flag, stop_seen: stop_flag,
                         owner: owner, rsvd: 1'b0};

    // Read data latched while waitrequest is still high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= TBE_READ_NONE;
        end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
            unique case (widx)
                TBE_IDX_DATA: begin
                    avs_readdata_o <= {24'h0, rx_sample, 7'h0};
                end
                TBE_IDX_CONTROL: avs_readdata_o <= {24'h0, ctl_r};
                TBE_IDX_CONFIG:  avs_readdata_o <= {24'h0, cfg};
                default:         avs_readdata_o <= TBE_READ_NONE;
            endcase
        end
    end

    // Timer fields are not built here, so they read back zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg <= TBE_CFG_RESET;
        end else if (ce_i && wr_cfg) begin
            cfg.slave_en <= avs_writedata_i[7];
            cfg.own_req  <= avs_writedata_i[6];
            cfg.timing   <= avs_writedata_i[1:0];
        end
    end

    assign min_cnt = TBE_CNT_W'((32'(cfg.timing) + 32'h1) * MIN_STEP);

    // Arbitration loss: all four cases, only while transmitting
    assign lost_set = xact & (
        (scl_rise & xbit & ~sda_s)
        | (start_det & xbit & ~rs_pend)
        | (st == TBE_M_HIGH & ~scl_s & rs_pend)
        | (st == TBE_M_STOP & cnt == '0 & ~sda_s));

    // Sets win over software clears on every flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_flag <= 1'b0;
        end else if (ce_i) begin
            if (scl_rise && active) begin
                ready_flag <= 1'b1;
            end else if ((wr_ctl && ctl_w.clr_ready)
                         || wr_data || rd_data) begin
                ready_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lost_flag <= 1'b0;
        end else if (ce_i) begin
            if (lost_set) begin
                lost_flag <= 1'b1;
            end else if (wr_ctl && ctl_w.clr_lost) begin
                lost_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_flag <= 1'b0;
        end else if (ce_i) begin
            if (start_det && active) begin
                start_flag <= 1'b1;
            end else if (wr_ctl && ctl_w.clr_start) begin
                start_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stop_flag <= 1'b0;
        end else if (ce_i) begin
            if (stop_det && active) begin
                stop_flag <= 1'b1;
            end else if (wr_ctl && ctl_w.clr_stop) begin
                stop_flag <= 1'b0;
            end
        end
    end

    // Ignoring ends at the next start, which itself sets no flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ignore <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctl && ctl_w.ignore_bus) begin
                ignore <= 1'b1;
            end else if (start_det) begin
                ignore <= 1'b0;
            end
        end
    end

    // Bus busy from start to stop; no timeout in this block
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
        end else if (ce_i) begin
            if (start_det) begin
                busy <= 1'b1;
            end else if (stop_det) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rel_pend <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctl && ctl_w.stop_req && !cfg.own_req) begin
                rel_pend <= 1'b1;
            end else if (stop_det || lost_set) begin
                rel_pend <= 1'b0;
            end
        end
    end

    // A pending request grants ownership whenever the bus is not busy
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            owner <= 1'b0;
        end else if (ce_i) begin
            if (lost_set || (stop_det && rel_pend)) begin
                owner <= 1'b0;
            end else if (cfg.own_req && !busy && !stop_det) begin
                owner <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            xact <= 1'b0;
        end else if (ce_i) begin
            if (lost_set) begin
                xact <= 1'b0;
            end else if (wr_data || (wr_ctl
                         && (ctl_w.rstart_req || ctl_w.stop_req))) begin
                xact <= 1'b1;
            end else if (rd_data || (wr_ctl && ctl_w.clr_xact)) begin
                xact <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            xbit <= 1'b1;
        end else if (ce_i) begin
            if (wr_data) begin
                xbit <= avs_writedata_i[TBE_DATA_BIT];
            end else if (wr_ctl && ctl_w.rstart_req) begin
                xbit <= 1'b1;
            end else if (wr_ctl && ctl_w.stop_req) begin
                xbit <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rs_pend <= 1'b0;
            sp_pend <= 1'b0;
        end else if (ce_i) begin
            if (lost_set
                || (st == TBE_M_RSTART && next_st != TBE_M_RSTART)) begin
                rs_pend <= 1'b0;
            end else if (wr_ctl && ctl_w.rstart_req) begin
                rs_pend <= 1'b1;
            end
            if (lost_set || (st == TBE_M_STOP && next_st != TBE_M_STOP)) begin
                sp_pend <= 1'b0;
            end else if (wr_ctl && ctl_w.stop_req) begin
                sp_pend <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_sample <= 1'b1;
        end else if (ce_i && scl_rise) begin
            rx_sample <= sda_s;
        end
    end

    // Owner clocking; counts run at least one minimum phase time
    always_comb begin
        next_st  = st;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        unique case (st)
            TBE_M_IDLE: begin
                if (owner && !busy) begin
                    next_st  = TBE_M_START;
                    next_cnt = min_cnt;
                end
            end
            TBE_M_START, TBE_M_RSTART: begin
                if (cnt == '0) begin
                    next_st  = TBE_M_LOW;
                    next_cnt = min_cnt;
                end
            end
            TBE_M_LOW: begin
                if (cnt == '0 && !attention) begin
                    next_st = TBE_M_RISE;
                end
            end
            TBE_M_RISE: begin
                if (scl_s) begin
                    next_st  = TBE_M_HIGH;
                    next_cnt = min_cnt;
                end
            end
            TBE_M_HIGH: begin
                if (!scl_s) begin
                    next_st  = TBE_M_LOW;
                    next_cnt = min_cnt;
                end else if (cnt == '0) begin
                    next_cnt = min_cnt;
                    if (rs_pend) begin
                        next_st = TBE_M_RSTART;
                    end else if (sp_pend) begin
                        next_st = TBE_M_STOP;
                    end else begin
                        next_st = TBE_M_LOW;
                    end
                end
            end
            TBE_M_STOP: begin
                if (cnt == '0) begin
                    next_st = TBE_M_IDLE;
                end
            end
        endcase
        if (lost_set || (!owner && st != TBE_M_STOP)) begin
            next_st = TBE_M_IDLE;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st  <= TBE_M_IDLE;
            cnt <= '0;
        end else if (ce_i) begin
            st  <= next_st;
            cnt <= next_cnt;
        end
    end

    // A target stretches only once SCL is already low
    assign next_scl_drive = (next_st == TBE_M_LOW)
        | (~owner & active & attention & ~scl_s);

    // SDA changes only in the low phase, except start and stop edges
    always_comb begin
        next_sda_drive = ~sda_oe_n_o;
        if (lost_set) begin
            next_sda_drive = 1'b0;
        end else if (st == TBE_M_IDLE && next_st == TBE_M_START) begin
            next_sda_drive = 1'b1;
        end else if (st == TBE_M_HIGH && next_st == TBE_M_RSTART) begin
            next_sda_drive = 1'b1;
        end else if (st == TBE_M_HIGH && next_st == TBE_M_STOP) begin
            next_sda_drive = 1'b0;
        end else if (st == TBE_M_START || st == TBE_M_RSTART
                     || st == TBE_M_STOP) begin
            next_sda_drive = ~sda_oe_n_o;
        end else if (!scl_s) begin
            next_sda_drive = xact & ~xbit;
        end
    end

    // Open-drain pins: data outputs stay low, enables do the work
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_o      <= 1'b0;
            sda_o      <= 1'b0;
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            scl_o      <= 1'b0;
            sda_o      <= 1'b0;
            scl_oe_n_o <= ~next_scl_drive;
            sda_oe_n_o <= ~next_sda_drive;
        end
    end

endmodule : tbe_engine

// ===== verif/tbe_engine_checker.sv
// Port-level assertions for the two-wire engine
`timescale 1ns/1ps
module tbe_engine_checker
    import tbe_pkg::*;
#(
    parameter int MIN_STEP = TBE_MIN_STEP_CYCLES
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  ce_i,
    input wire logic [TBE_ADDR_W-1:0] avs_address_i,
    input wire logic                  avs_read_i,
    input wire logic                  avs_write_i,
    input wire logic [31:0]           avs_readdata_o,
    input wire logic                  avs_waitrequest_o,
    input wire logic                  scl_i,
    input wire logic                  scl_o,
    input wire logic                  sda_o,
    input wire logic                  sda_oe_n_o
);
    logic [7:0] idx;
    logic       rd_new;
    logic       unmapped;
    assign idx = avs_address_i[9:2];
    assign rd_new = avs_read_i && avs_waitrequest_o;
    assign unmapped = idx != TBE_IDX_CONFIG && idx != TBE_IDX_CONTROL
                      && idx != TBE_IDX_DATA;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_wait_answer: assert property (
        ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("access not answered");
    a_wait_pulse: assert property (
        $fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_no_spurious: assert property (
        !avs_read_i && !avs_write_i && avs_waitrequest_o
        |=> avs_waitrequest_o) else $error("answer without request");
    a_pins_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin data not low");
    a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (
        rd_new && unmapped |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_data_unused: assert property (
        rd_new && idx == TBE_IDX_DATA |=> avs_readdata_o[6:0] == 7'h0)
        else $error("data unused bits set");
    a_attn_flags: assert property (
        avs_read_i && !avs_waitrequest_o && idx == TBE_IDX_CONTROL
        |-> avs_readdata_o[6] == (|avs_readdata_o[5:2]))
        else $error("attention not flag sum");
    c_ctl_write: cover property (
        avs_write_i && !avs_waitrequest_o && idx == TBE_IDX_CONTROL);
    c_sda_pull: cover property (!sda_oe_n_o && scl_i);
    c_ctl_read: cover property (rd_new && idx == TBE_IDX_CONTROL);
endmodule : tbe_engine_checker

bind tbe_engine tbe_engine_checker #(.MIN_STEP(MIN_STEP))
    tbe_engine_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_i),
    .scl_o(scl_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));

// ===== verif/tbe_bus_model.sv
// Behavioural far-side party on the two-wire bus
`timescale 1ns/1ps
module tbe_bus_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_pull_o,
    output logic      sda_pull_o
);
    localparam int HALF = 4;    // 80 ns half period of the link clock
    int   starts   = 0;
    int   stops    = 0;
    logic last_bit = 1'b1;
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end
    always @(negedge sda_i) if (!rst_i && scl_i === 1'b1) starts++;
    always @(posedge sda_i) if (!rst_i && scl_i === 1'b1) stops++;
    always @(posedge scl_i) last_bit = sda_i;
    // Competing transmitter sends 0 on the coming bit
    task automatic pull_sda();
        @(posedge clk_i);
        sda_pull_o <= 1'b1;
    endtask : pull_sda
    // Clock stays still between frames, so a stop is driven whole here
    task automatic send_stop();
        @(posedge clk_i);
        scl_pull_o <= 1'b1;
        sda_pull_o <= 1'b1;
        repeat (HALF) @(posedge clk_i);
        scl_pull_o <= 1'b0;
        @(posedge clk_i);
        while (scl_i !== 1'b1) @(posedge clk_i);
        repeat (HALF) @(posedge clk_i);
        sda_pull_o <= 1'b0;
        @(posedge clk_i);
    endtask : send_stop
endmodule : tbe_bus_model

// ===== verif/tbe_engine_test.sv
// Self-checking bench for the two-wire engine
`timescale 1ns/1ps
module tbe_engine_test;
    import tbe_pkg::*;
    localparam int STEP  = 2;       // Short phases keep the run brief
    localparam int LIMIT = 20000;   // Tests need a few hundred cycles
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  ce_i  = 1'b1;
    logic [TBE_ADDR_W-1:0] avs_address_i = '0;
    logic                  avs_read_i = 1'b0;
    logic                  avs_write_i = 1'b0;
    logic [31:0]           avs_writedata_i = '0;
    logic [3:0]            avs_byteenable_i = '0;
    logic [31:0]           avs_readdata_o;
    logic                  avs_waitrequest_o;
    logic                  scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
    logic                  scl_pull, sda_pull, scl_w, sda_w;
    logic [31:0]           d;
    int                    miscompares = 0;
    int                    compares = 0;
    int                    cycles = 0;
    assign scl_w = scl_oe_n_o & ~scl_pull;   // Pull-ups on both wires
    assign sda_w = sda_oe_n_o & ~sda_pull;
    always #10 clk_i = ~clk_i;
    tbe_engine #(.MIN_STEP(STEP)) tbe_engine_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
    tbe_bus_model tbe_bus_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
        .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= {24'h0, wd};
        avs_byteenable_i <= be;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        check("bus_wait", 32'h2, n);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, 4'h1, rd);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                          input logic [7:0] mask, input string name);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, 4'h1, rd);
        check(name, {24'h0, exp & mask}, rd & {24'hFFFFFF, mask});
    endtask : rd_chk
    // Control reads have no side effects, so polling is safe
    task automatic poll(input logic [7:0] mask);
        logic [31:0] rd;
        int n;
        rd = '0;
        n = 0;
        while ((rd[7:0] & mask) !== mask && n < 200) begin
            bus(1'b0, TBE_IDX_CONTROL, 8'h00, 4'h1, rd);
            n++;
        end
        check("poll", {24'h0, mask}, {24'h0, rd[7:0] & mask});
    endtask : poll
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(TBE_IDX_CONTROL, 8'h80, 8'hFF, "ctl_reset");
        rd_chk(TBE_IDX_DATA, 8'h80, 8'hFF, "data_reset");
        rd_chk(TBE_IDX_CONFIG, 8'h00, 8'hFF, "cfg_reset");
        rd_chk(8'h10, 8'h00, 8'hFF, "unmapped");
        check("sda_idle", 32'h1, {31'h0, sda_oe_n_o});
        wr_reg(TBE_IDX_CONFIG, 8'h40);
        poll(8'h08);
        rd_chk(TBE_IDX_CONTROL, 8'hCA, 8'hFF, "ctl_start");
        check("starts", 32'd1, tbe_bus_model_inst.starts);
        wr_reg(TBE_IDX_CONTROL, 8'h00);
        bus(1'b1, TBE_IDX_CONTROL, 8'h08, 4'h0, d);
        wr_reg(TBE_IDX_DATA, 8'h00);
        repeat (40) @(posedge clk_i);
        rd_chk(TBE_IDX_CONTROL, 8'hCA, 8'hFF, "ctl_held");
        check("scl_held", 32'h0, {31'h0, scl_oe_n_o});
        check("sda_zero", 32'h0, {31'h0, sda_oe_n_o});
        wr_reg(TBE_IDX_CONTROL, 8'h08);
        ce_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        check("ce_freeze", 32'h0, {31'h0, scl_oe_n_o});
        ce_i <= 1'b1;
        poll(8'h20);
        rd_chk(TBE_IDX_CONTROL, 8'h62, 8'hFF, "ctl_bit");
        check("bit", 32'h0, {31'h0, tbe_bus_model_inst.last_bit});
        tbe_bus_model_inst.pull_sda();
        wr_reg(TBE_IDX_DATA, 8'h80);
        poll(8'h10);
        rd_chk(TBE_IDX_CONTROL, 8'h70, 8'hFF, "ctl_lost");
        check("sda_free", 32'h1, {31'h0, sda_oe_n_o});
        rd_chk(TBE_IDX_DATA, 8'h00, 8'hFF, "data_rx");
        wr_reg(TBE_IDX_CONTROL, 8'h10);
        rd_chk(TBE_IDX_CONTROL, 8'h00, 8'h7E, "ctl_clear");
        tbe_bus_model_inst.send_stop();
        check("stops", 32'd1, tbe_bus_model_inst.stops);
        poll(8'h0A);
        rd_chk(TBE_IDX_CONTROL, 8'h4A, 8'h7E, "ctl_regain");
        check("starts", 32'd2, tbe_bus_model_inst.starts);
        wr_reg(TBE_IDX_CONTROL, 8'h2A);
        poll(8'h08);
        check("starts", 32'd3, tbe_bus_model_inst.starts);
        wr_reg(TBE_IDX_CONFIG, 8'h00);
        wr_reg(TBE_IDX_CONTROL, 8'h29);
        poll(8'h04);
        rd_chk(TBE_IDX_CONTROL, 8'h44, 8'h46, "ctl_stop");
        check("stops", 32'd2, tbe_bus_model_inst.stops);
        check("sda_line", 32'h1, {31'h0, sda_w});
        wr_reg(TBE_IDX_CONTROL, 8'hE4);
        wr_reg(TBE_IDX_CONFIG, 8'h80);
        tbe_bus_model_inst.send_stop();
        rd_chk(TBE_IDX_CONTROL, 8'h00, 8'h7E, "ctl_ignored");
        check("stops", 32'd3, tbe_bus_model_inst.stops);
        finish_test();
    end
endmodule : tbe_engine_test
